/* File: ssa_pkg.sv */
// Purpose: shared constants and types for the serial sram access block
// Assumes: single system clock, spi pins synchronous to it
// Notes: memory is 64K x 8, one-bit spi path only
package ssa_pkg;

    // ------------------------------------------------------------
    // instruction codes and field sizes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam int CMD_BITS = 8;
    localparam int ADDR_BITS = 16;
    localparam int DATA_BITS = 8;
    localparam int PAGE_BITS = 5;
    localparam int MEM_WORDS = 65536;
    localparam logic [3:0] CMD_LAST_BIT = 4'h7;
    localparam logic [3:0] ADDR_LAST_BIT = 4'hF;
    localparam logic [2:0] OUT_LAST_BIT = 3'h7;

    // ------------------------------------------------------------
    // mode register layout
    // ------------------------------------------------------------
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam logic [1:0] MODE_BYTE = 2'h0;
    localparam logic [1:0] MODE_SEQ = 2'h1;
    localparam logic [1:0] MODE_PAGE = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    localparam logic [7:0] MODE_RESET = 8'h40;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } ssa_word_t;

endpackage

/* File: ssa_pair_buf.sv */
// Purpose: two-entry fifo with valid/ready on both sides
// Assumes: flush empties it in one cycle
// Notes: full and empty are exact; push is refused when full
module ssa_pair_buf #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [PW:0] next_count;
    logic do_push;
    logic do_pop;

    assign in_ready = (count != DEPTH[PW:0]);
    assign out_valid = (count != '0);
    assign out_data = store[rd_ptr];

    always_comb
    begin
        do_push = in_valid && in_ready && !flush;
        do_pop = out_valid && out_ready && !flush;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (flush)
        begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end
        else
        begin
            if (do_push)
                next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (do_pop)
                next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            if (do_push && !do_pop)
                next_count = count + 1'b1;
            else if (do_pop && !do_push)
                next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage carries no reset: contents only count once pushed
    always_ff @(posedge clock)
    begin
        if (do_push)
            store[wr_ptr] <= in_data;
    end

endmodule

/* File: ssa_spi_sram.sv */
// Purpose: spi slave front end and array of a 64K x 8 static ram
// Assumes: sclk, cs_n, mosi synchronous to clock, sclk well below clock/4
// Notes: mode register is loaded from the mode_wr/mode_wdata side port

// Overview of operation
// - an 8-bit instruction register captures the first byte after selection
// - instruction, address and write data sampled on sclk rising edges
// - all bytes shifted most significant bit first, both directions
// - mode field bits 7:6 pick byte, page or sequential addressing
// - mode 00 limits each read or write to one byte
// - byte mode moves data in the eight clocks after the address
// - mode 10 increments the address within 32-byte pages
// - page mode wraps from the page end back to its start
// - mode 01 increments across page boundaries over the whole array
// - read shifts out the stored byte after instruction and address
// - sequential read continues, address wrapping FFFF to 0000
// - raising cs_n ends a read and stops the output
// - read opcode 03, write opcode 02, then address, then data
// - mode resets to sequential, reserved value 11 is refused
// - serial output changes after each falling sclk edge
// - write is instruction, address, data bytes, ended by cs_n high
module ssa_spi_sram (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    output logic miso,
    output logic miso_oe,
    output logic [7:0] mode_reg
);

    // ------------------------------------------------------------
    // state and storage
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_CMD = 5'h01,
        ST_ADDR = 5'h02,
        ST_READ = 5'h04,
        ST_WRITE = 5'h08,
        ST_IGNORE = 5'h10
    } ssa_state_t;

    logic [7:0] mem [ssa_pkg::MEM_WORDS];

    ssa_state_t state, next_state;
    logic sclk_q, next_sclk_q;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [15:0] shift_in, next_shift_in;
    logic is_read, next_is_read;
    logic [15:0] wr_addr, next_wr_addr;
    logic [15:0] fetch_addr, next_fetch_addr;
    logic byte_done, next_byte_done;
    logic fetch_done, next_fetch_done;
    logic [7:0] out_sh, next_out_sh;
    logic [2:0] out_cnt, next_out_cnt;
    logic next_miso, next_miso_oe;
    logic [7:0] next_mode_reg;

    logic rise, fall;
    logic wr_en;
    logic [7:0] wr_data;
    logic push, pop;
    logic buf_in_ready, buf_out_valid;
    ssa_pkg::ssa_word_t push_word, pop_word;
    logic [1:0] mode;

    assign mode = mode_reg[ssa_pkg::MODE_MSB:ssa_pkg::MODE_LSB];
    assign rise = sclk && !sclk_q && !cs_n;
    assign fall = !sclk && sclk_q && !cs_n;

    // address step depends on the mode field
    function automatic logic [15:0] step_addr(input logic [15:0] a,
                                              input logic [1:0] m);
        logic [15:0] r;
        r = a + 16'h0001;
        if (m == ssa_pkg::MODE_PAGE)
            r = {a[15:ssa_pkg::PAGE_BITS],
                 a[ssa_pkg::PAGE_BITS-1:0] + 5'h01};
        return r;
    endfunction

    // ------------------------------------------------------------
    // read prefetch buffer
    // ------------------------------------------------------------
    // prefetch keeps the next byte ready before the shifter needs it
    ssa_pair_buf #(
        .WIDTH($bits(ssa_pkg::ssa_word_t)),
        .DEPTH(2)
    ) u_buf (
        .clock(clock),
        .arst_n(arst_n),
        .flush(cs_n),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(push_word),
        .out_valid(buf_out_valid),
        .out_ready(pop),
        .out_data(pop_word)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_sclk_q = sclk;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_is_read = is_read;
        next_wr_addr = wr_addr;
        next_fetch_addr = fetch_addr;
        next_byte_done = byte_done;
        next_fetch_done = fetch_done;
        next_out_sh = out_sh;
        next_out_cnt = out_cnt;
        next_miso = miso;
        next_miso_oe = miso_oe;
        next_mode_reg = mode_reg;
        wr_en = 1'b0;
        wr_data = shift_in[7:0];
        push = 1'b0;
        pop = 1'b0;
        push_word = '{addr: fetch_addr, data: mem[fetch_addr]};

        // reserved mode value is dropped, register keeps its old mode
        if (mode_wr && mode_wdata[ssa_pkg::MODE_MSB:ssa_pkg::MODE_LSB]
            != ssa_pkg::MODE_RSVD)
            next_mode_reg = {mode_wdata[ssa_pkg::MODE_MSB:ssa_pkg::MODE_LSB],
                             6'h00};

        if (cs_n)
        begin
            next_state = ST_CMD;
            next_bit_cnt = 4'h0;
            next_out_cnt = 3'h0;
            next_miso_oe = 1'b0;
            next_byte_done = 1'b0;
            next_fetch_done = 1'b0;
        end
        else
        begin
            if (rise)
            begin
                next_shift_in = {shift_in[14:0], mosi};
                next_bit_cnt = bit_cnt + 4'h1;
                case (state)
                    ST_CMD:
                    begin
                        if (bit_cnt == ssa_pkg::CMD_LAST_BIT)
                        begin
                            next_bit_cnt = 4'h0;
                            if (next_shift_in[7:0] == ssa_pkg::CMD_READ)
                            begin
                                next_state = ST_ADDR;
                                next_is_read = 1'b1;
                            end
                            else if (next_shift_in[7:0] == ssa_pkg::CMD_WRITE)
                            begin
                                next_state = ST_ADDR;
                                next_is_read = 1'b0;
                            end
                            else
                                next_state = ST_IGNORE;
                        end
                    end
                    ST_ADDR:
                    begin
                        if (bit_cnt == ssa_pkg::ADDR_LAST_BIT)
                        begin
                            next_bit_cnt = 4'h0;
                            next_wr_addr = next_shift_in;
                            next_fetch_addr = next_shift_in;
                            next_state = is_read ? ST_READ : ST_WRITE;
                        end
                    end
                    ST_WRITE:
                    begin
                        if (bit_cnt == ssa_pkg::CMD_LAST_BIT)
                        begin
                            next_bit_cnt = 4'h0;
                            if (!byte_done)
                            begin
                                wr_en = 1'b1;
                                wr_data = next_shift_in[7:0];
                                next_wr_addr = step_addr(wr_addr, mode);
                                next_byte_done =
                                    (mode == ssa_pkg::MODE_BYTE);
                            end
                        end
                    end
                    default:
                        next_bit_cnt = 4'h0;
                endcase
            end

            if (state == ST_READ)
            begin
                if (buf_in_ready && !fetch_done)
                begin
                    push = 1'b1;
                    next_fetch_addr = step_addr(fetch_addr, mode);
                    next_fetch_done = (mode == ssa_pkg::MODE_BYTE);
                end
                if (fall)
                begin
                    if (out_cnt == 3'h0)
                    begin
                        if (buf_out_valid)
                        begin
                            pop = 1'b1;
                            next_miso = pop_word.data[7];
                            next_out_sh = {pop_word.data[6:0], 1'b0};
                            next_out_cnt = ssa_pkg::OUT_LAST_BIT;
                            next_miso_oe = 1'b1;
                        end
                        else
                            next_miso_oe = 1'b0;
                    end
                    else
                    begin
                        next_miso = out_sh[7];
                        next_out_sh = {out_sh[6:0], 1'b0};
                        next_out_cnt = out_cnt - 3'h1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_CMD;
            sclk_q <= 1'b0;
            bit_cnt <= 4'h0;
            shift_in <= 16'h0000;
            is_read <= 1'b0;
            wr_addr <= 16'h0000;
            fetch_addr <= 16'h0000;
            byte_done <= 1'b0;
            fetch_done <= 1'b0;
            out_sh <= 8'h00;
            out_cnt <= 3'h0;
            miso <= 1'b0;
            miso_oe <= 1'b0;
            mode_reg <= ssa_pkg::MODE_RESET;
        end
        else
        begin
            state <= next_state;
            sclk_q <= next_sclk_q;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            is_read <= next_is_read;
            wr_addr <= next_wr_addr;
            fetch_addr <= next_fetch_addr;
            byte_done <= next_byte_done;
            fetch_done <= next_fetch_done;
            out_sh <= next_out_sh;
            out_cnt <= next_out_cnt;
            miso <= next_miso;
            miso_oe <= next_miso_oe;
            mode_reg <= next_mode_reg;
        end
    end

    // array has no reset, as a real sram powers up undefined
    always_ff @(posedge clock)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

endmodule

/* File: ssa_spi_sram_monitor.sv */
// Purpose: port assertions for the spi sram access block
// Assumes: one clock domain, arst_n active low
// Notes: sclk edges are found the same way the block finds them
module ssa_spi_sram_monitor (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic [7:0] mode_reg
);
    timeunit 1ns;
    timeprecision 100ps;

    logic sclk_d;
    logic fall;
    logic [5:0] rises;
    logic [5:0] next_rises;

    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // ----------------------------------------
    // rise counter, saturates so it never wraps
    // ----------------------------------------
    assign fall = sclk_d & ~sclk & ~cs_n;

    always_comb
    begin
        next_rises = rises;
        if (cs_n)
            next_rises = 6'h00;
        else if (sclk & ~sclk_d & (rises != 6'h3F))
            next_rises = rises + 6'h01;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclk_d <= 1'b0;
            rises <= 6'h00;
        end
        else
        begin
            sclk_d <= sclk;
            rises <= next_rises;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_oe_desel: assert property (cs_n |=> !miso_oe)
        else $error("output enabled while deselected");
    chk_bit_fall: assert property (miso_oe && $past(miso_oe)
        && $changed(miso) |-> $past(fall))
        else $error("output bit moved without an sclk fall");
    chk_oe_fall: assert property ($rose(miso_oe) |-> $past(fall))
        else $error("output enable rose without an sclk fall");
    chk_oe_addr: assert property (miso_oe |-> rises >= 6'h18)
        else $error("output before opcode and address done");
    chk_byte_one: assert property (mode_reg[7:6] == 2'h0
        && rises > 6'h20 |-> !miso_oe)
        else $error("byte mode drove past one byte");
    chk_mode_load: assert property (mode_wr
        && mode_wdata[7:6] != 2'h3
        |=> mode_reg == {$past(mode_wdata[7:6]), 6'h00})
        else $error("mode write not loaded");
    chk_mode_rsvd: assert property (mode_wr
        && mode_wdata[7:6] == 2'h3 |=> $stable(mode_reg))
        else $error("reserved mode accepted");
    chk_mode_idle: assert property (!mode_wr |=> $stable(mode_reg))
        else $error("mode changed without a write");
    chk_mode_form: assert property (mode_reg[5:0] == 6'h00
        && mode_reg[7:6] != 2'h3)
        else $error("mode register holds a bad value");
endmodule

bind ssa_spi_sram ssa_spi_sram_monitor u_ssa_spi_sram_monitor (
    .clock(clock),
    .arst_n(arst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .mode_wr(mode_wr),
    .mode_wdata(mode_wdata),
    .miso(miso),
    .miso_oe(miso_oe),
    .mode_reg(mode_reg)
);

/* File: ssa_spi_master.sv */
// Purpose: behavioural spi master facing the sram access block
// Assumes: spi mode 0, sclk 10 clocks per bit
// Notes: data line is inverted while deselected so no stale bit shows
module ssa_spi_master (
    input wire logic clock,
    input wire logic so,
    output logic sclk,
    output logic cs_n,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    // ----------------------------------------
    // byte exchange, sampled just before sclk rises
    // ----------------------------------------
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            mosi = tx[i];
            tick(5);
            rx[i] = so;
            sclk = 1'b1;
            tick(5);
            sclk = 1'b0;
        end
    endtask

    task automatic start(input logic [7:0] op, input logic [15:0] a);
        logic [7:0] rx;
        cs_n = 1'b0;
        tick(3);
        xb(op, rx);
        xb(a[15:8], rx);
        xb(a[7:0], rx);
    endtask

    task automatic stop();
        tick(3);
        cs_n = 1'b1;
        mosi = ~mosi;
        tick(4);
    endtask

    // frame cut after n bits, mid-byte; cs_n going high then clears the bit counter
    task automatic cut(input int n);
        cs_n = 1'b0;
        tick(3);
        repeat (n)
        begin
            mosi = 1'b1;
            tick(5);
            sclk = 1'b1;
            tick(5);
            sclk = 1'b0;
        end
        stop();
    endtask
endmodule

/* File: serial_sram_spi_access_test.sv */
// Purpose: self-checking bench for the spi sram access block
// Assumes: master model drives the spi pins at falling clock edges
// Notes: memory is unreset, so only written places are read back
module serial_sram_spi_access_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic mode_wr = 1'b0;
    logic [7:0] mode_wdata = 8'h00;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic [7:0] mode_reg;
    wire so = miso_oe ? miso : 1'bz;
    int errors = 0;
    int n_compared = 0;
    logic [7:0] tx [4];
    logic [7:0] rx [4];

    always #2.5 clock = ~clock;

    ssa_spi_sram u_ssa_spi_sram (
        .clock(clock),
        .arst_n(arst_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi),
        .mode_wr(mode_wr),
        .mode_wdata(mode_wdata),
        .miso(miso),
        .miso_oe(miso_oe),
        .mode_reg(mode_reg)
    );

    ssa_spi_master u_ssa_spi_master (
        .clock(clock),
        .so(so),
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic final_report();
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic run(input logic [7:0] op, input logic [15:0] a,
                       input int n);
        u_ssa_spi_master.start(op, a);
        for (int i = 0; i < n; i++)
            u_ssa_spi_master.xb(tx[i], rx[i]);
        u_ssa_spi_master.stop();
    endtask

    task automatic set_mode(input logic [7:0] v, input logic [7:0] exp);
        mode_wr = 1'b1;
        mode_wdata = v;
        @(negedge clock);
        mode_wr = 1'b0;
        @(negedge clock);
        check("mode_reg", mode_reg, exp);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_seq();
        tx = '{8'hA5, 8'h3C, 8'h5A, 8'h00};
        run(ssa_pkg::CMD_WRITE, 16'hFFFE, 3);
        run(ssa_pkg::CMD_READ, 16'hFFFE, 3);
        for (int i = 0; i < 3; i++)
            check("seq read", rx[i], tx[i]);
        run(ssa_pkg::CMD_READ, 16'h0000, 1);
        check("seq wrap", rx[0], 8'h5A);
    endtask

    task automatic t_page();
        set_mode(8'h80, 8'h80);
        tx = '{8'h11, 8'h22, 8'h33, 8'h00};
        run(ssa_pkg::CMD_WRITE, 16'h013E, 3);
        run(ssa_pkg::CMD_READ, 16'h0120, 1);
        check("page wrap", rx[0], 8'h33);
        run(ssa_pkg::CMD_READ, 16'h013F, 2);
        check("page read", rx[0], 8'h22);
        check("page read", rx[1], 8'h33);
    endtask

    // a stepped second byte would overwrite 0000, just past FFFF
    task automatic t_byte();
        set_mode(8'h3F, 8'h00);
        tx = '{8'h44, 8'h55, 8'h00, 8'h00};
        run(ssa_pkg::CMD_WRITE, 16'hFFFF, 2);
        run(ssa_pkg::CMD_READ, 16'h0000, 1);
        check("byte keep", rx[0], 8'h5A);
        run(ssa_pkg::CMD_READ, 16'hFFFF, 2);
        check("byte read", rx[0], 8'h44);
        check("byte stop", rx[1], 8'hZZ);
    endtask

    task automatic t_reject();
        set_mode(8'hC0, 8'h00);
        set_mode(8'h40, 8'h40);
        run(8'h05, 16'h013F, 1);
        check("bad opcode", rx[0], 8'hZZ);
        u_ssa_spi_master.cut(3);
        run(ssa_pkg::CMD_READ, 16'hFFFF, 1);
        check("fresh read", rx[0], 8'h44);
        check("released", {7'h00, miso_oe}, 8'h00);
    endtask

    initial
    begin
        repeat (20) @(negedge clock);
        arst_n = 1'b1;
        repeat (2) @(negedge clock);
        check("mode_reg", mode_reg, 8'h40);
        check("miso_oe", {7'h00, miso_oe}, 8'h00);
        t_seq();
        t_page();
        t_byte();
        t_reject();
        final_report();
    end

    // about four and a half times the expected run length
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        final_report();
    end
endmodule
